// ===== hdl/pcc_pkg.sv
// constants and types of the common control wrapper of one peripheral
// assumes one 50 MHz bus clock and an AXI4-Lite register bus with 13-bit byte addresses
// How it works
// - peripheral reset sets a sticky read-only bit 16 of the status register
// - sticky bit clears only on reset control write with clear bit and key B1h
// - functional clock divided by divide field bits 2-0 plus one
// - source pick bits 3/2/1 choose bus/mid/low clock, only while that clock enabled
// - free-run bit 0 low freezes function during core halt; resets to one
// - soft-halt bit 1 high delays freeze until a safe boundary; resets to one
// - index register shows highest-priority pending enabled interrupt, zero when none
// - lowest-numbered set interrupt bit wins; each read reports exactly one
// - processor read of index clears reported interrupt and its raw and masked flags
// - after processor read index moves to next pending; debug reads change nothing
// - index is 8-bit code: interrupt bit number plus one
// - raw interrupt takes part in index only while its mask bit is one
package pcc_pkg;

	localparam int ADDR_W = 13;
	localparam int DATA_W = 32;
	localparam int IRQ_N  = 32;

	// register byte addresses
	localparam logic [ADDR_W-1:0] OFF_RESET_CTRL  = 13'h0804;
	localparam logic [ADDR_W-1:0] OFF_STATUS      = 13'h0814;
	localparam logic [ADDR_W-1:0] OFF_CLK_DIVIDE  = 13'h1000;
	localparam logic [ADDR_W-1:0] OFF_CLK_SELECT  = 13'h1008;
	localparam logic [ADDR_W-1:0] OFF_DEBUG_CTRL  = 13'h1018;
	localparam logic [ADDR_W-1:0] OFF_IRQ_INDEX   = 13'h1020;

	// field positions
	localparam int POS_STICKY    = 16;
	localparam int POS_KEY_LO    = 24;
	localparam int POS_STICKY_CLR = 1;
	localparam int POS_RESET_ASSERT = 0;
	localparam int POS_BUS_PICK  = 3;
	localparam int POS_MID_PICK  = 2;
	localparam int POS_LOW_PICK  = 1;
	localparam int POS_FREE      = 0;
	localparam int POS_SOFT      = 1;

	localparam logic [7:0] RESET_KEY = 8'hB1;

	// values after reset
	localparam logic [2:0] RST_RATIO     = 3'h0;
	localparam logic [2:0] RST_SELECT    = 3'h0;
	localparam logic [1:0] RST_DEBUG     = 2'h3;
	localparam logic [7:0] IDX_NONE      = 8'h00;

	// bus responses
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef logic [2:0] clk_pick_t;

endpackage : pcc_pkg

// ===== hdl/pcc_link_if.sv
// signals shared by the top of the wrapper and its clock and interrupt helpers
// assumes all three modules run on the same bus clock
`timescale 1ns/1ns
interface pcc_link_if;
	import pcc_pkg::*;
	clk_pick_t           pick;       // {bus, mid, low} pick bits
	logic [2:0]          ratio;
	logic                funcTick;   // one pulse per functional clock period
	logic [IRQ_N-1:0]    mask;
	logic [7:0]          curIndex;
	logic                indexRead;  // processor read of the index register
	logic [IRQ_N-1:0]    rawFlags;

	modport clkTop  (output pick, output ratio, input funcTick);
	modport clkSide (input pick, input ratio, output funcTick);
	modport irqTop  (output mask, output indexRead, input curIndex, input rawFlags);
	modport irqSide (input mask, input indexRead, output curIndex, output rawFlags);
endinterface : pcc_link_if

// ===== hdl/pcc_clock_gen.sv
// functional clock as a tick stream: pick a source, then divide it
// assumes mid and low clock ticks are one-cycle pulses on the bus clock
`timescale 1ns/1ns
module pcc_clock_gen
	import pcc_pkg::*;
(
	input  wire logic sys_clk,
	input  wire logic reset_n,
	input  wire logic busClkEn,
	input  wire logic midClkEn,
	input  wire logic lowClkEn,
	input  wire logic midTick,
	input  wire logic lowTick,
	pcc_link_if.clkSide link
);
	logic [2:0] divCount_r;
	logic       tick_r;
	logic       busOn;
	logic       midOn;
	logic       lowOn;
	logic       srcTick;
	logic       wrap;

	// a pick counts only while its clock is enabled; ticks of all enabled picks are ORed
	assign busOn   = link.pick[2] & busClkEn;
	assign midOn   = link.pick[1] & midClkEn;
	assign lowOn   = link.pick[0] & lowClkEn;
	assign srcTick = busOn | (midOn & midTick) | (lowOn & lowTick);
	assign wrap    = (divCount_r >= link.ratio);

	// divide the chosen source by ratio plus one
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			divCount_r <= 3'h0;
			tick_r     <= 1'b0;
		end else begin
			tick_r <= srcTick & wrap;
			if (srcTick) begin
				divCount_r <= wrap ? 3'h0 : divCount_r + 3'h1;
			end
		end
	end

	assign link.funcTick = tick_r;
endmodule : pcc_clock_gen

// ===== hdl/pcc_irq_index.sv
// raw interrupt flags and the fixed-priority index that clears on read
// assumes event pulses and the read strobe are on the bus clock
`timescale 1ns/1ns
module pcc_irq_index
	import pcc_pkg::*;
(
	input  wire logic             sys_clk,
	input  wire logic             reset_n,
	input  wire logic [IRQ_N-1:0] events,
	pcc_link_if.irqSide           link
);
	logic [IRQ_N-1:0] raw_r;
	logic [IRQ_N-1:0] masked;
	logic [IRQ_N-1:0] clearHit;
	logic [7:0]       index;

	assign masked = raw_r & link.mask;

	// lowest set bit wins; code is bit number plus one
	always_comb begin
		index = IDX_NONE;
		for (int i = IRQ_N - 1; i >= 0; i--) begin
			if (masked[i]) begin
				index = 8'(i + 1);
			end
		end
	end

	// each flag: event sets, index read clears, set wins
	for (genvar g = 0; g < IRQ_N; g++) begin : gFlag
		assign clearHit[g] = link.indexRead && (index == 8'(g + 1));
		always_ff @(posedge sys_clk or negedge reset_n) begin
			if (!reset_n) begin
				raw_r[g] <= 1'b0;
			end else if (events[g]) begin
				raw_r[g] <= 1'b1;
			end else if (clearHit[g]) begin
				raw_r[g] <= 1'b0;
			end
		end
	end

	assign link.curIndex = index;
	assign link.rawFlags = raw_r;
endmodule : pcc_irq_index

// ===== hdl/peripheral_common_ctrl.sv
// common control and status wrapper: reset sticky, clock pick and divide,
// debug halt and the interrupt index, behind an AXI4-Lite slave
// assumes core halt arrives from another domain; everything else is on sys_clk
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ns
module peripheral_common_ctrl
	import pcc_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic              reset_n,
	// AXI4-Lite slave
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	input  wire logic [DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	output logic [1:0]             s_axi_bresp,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              arDebug,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic [DATA_W-1:0]      s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	// peripheral side
	input  wire logic              periphResetIn,
	output logic                   periphResetOut,
	input  wire logic [IRQ_N-1:0]  irqEvents,
	input  wire logic [IRQ_N-1:0]  interrupt_mask,
	output logic [IRQ_N-1:0]       raw_interrupt_flags,
	input  wire logic              busClkEn,
	input  wire logic              midClkEn,
	input  wire logic              lowClkEn,
	input  wire logic              midTick,
	input  wire logic              lowTick,
	output logic                   funcClkTick,
	input  wire logic              coreHalted,
	input  wire logic              safeBoundary,
	output logic                   functionRun
);
	pcc_link_if link ();

	// write channel state
	logic              awReady_r;
	logic              wReady_r;
	logic [ADDR_W-1:0] wrAddr_r;
	logic [DATA_W-1:0] wrData_r;
	logic [3:0]        wrStrb_r;
	logic              bValid_r;
	logic [1:0]        bResp_r;
	// read channel state
	logic              arReady_r;
	logic              rValid_r;
	logic [DATA_W-1:0] rData_r;
	logic [1:0]        rResp_r;
	// registers
	logic              sticky_r;
	logic [2:0]        ratio_r;
	clk_pick_t         pick_r;
	logic [1:0]        dbgCtl_r;
	logic              resetPulse_r;
	logic [IRQ_N-1:0]  rawOut_r;
	logic              tickOut_r;
	// halt synchroniser and freeze
	logic              haltS1_r;
	logic              haltS2_r;
	logic              haltS3_r;
	logic              haltSeen_r;
	logic              frozen_r;
	logic              run_r;

	// a write is applied in the single cycle in which both halves are held and
	// no answer is pending; awready and wready stay low until then, so a second
	// request cannot overwrite the address or data being applied
	// write decode
	logic              doWrite;
	logic              wrRstCtl;
	logic              wrDivide;
	logic              wrSelect;
	logic              wrDebug;
	logic              wrMapped;
	logic              keyOk;
	logic              stickyClear;
	logic              resetAssert;
	logic              stickySet;

	assign doWrite  = !awReady_r && !wReady_r && !bValid_r;
	assign wrRstCtl = doWrite && (wrAddr_r == OFF_RESET_CTRL);
	assign wrDivide = doWrite && (wrAddr_r == OFF_CLK_DIVIDE) && wrStrb_r[0];
	assign wrSelect = doWrite && (wrAddr_r == OFF_CLK_SELECT) && wrStrb_r[0];
	assign wrDebug  = doWrite && (wrAddr_r == OFF_DEBUG_CTRL) && wrStrb_r[0];
	assign wrMapped = (wrAddr_r == OFF_RESET_CTRL) || (wrAddr_r == OFF_STATUS)
		|| (wrAddr_r == OFF_CLK_DIVIDE) || (wrAddr_r == OFF_CLK_SELECT)
		|| (wrAddr_r == OFF_DEBUG_CTRL) || (wrAddr_r == OFF_IRQ_INDEX);

	// keyed reset control: key byte and control byte must both be written
	assign keyOk       = wrRstCtl && wrStrb_r[3] && wrStrb_r[0]
		&& (wrData_r[POS_KEY_LO +: 8] == RESET_KEY);
	assign stickyClear = keyOk && wrData_r[POS_STICKY_CLR];
	assign resetAssert = keyOk && wrData_r[POS_RESET_ASSERT];
	assign stickySet   = periphResetIn || resetPulse_r;

	// read address is decoded straight from the bus; it is only used in the
	// cycle that takes it, so no copy of the address is kept
	// read decode
	logic              rdTake;
	logic [DATA_W-1:0] rdMux;
	logic              rdMapped;
	logic              rdIndex;

	assign rdTake  = s_axi_arvalid && arReady_r;
	assign rdIndex = s_axi_araddr == OFF_IRQ_INDEX;
	assign rdMapped = (s_axi_araddr == OFF_RESET_CTRL) || (s_axi_araddr == OFF_STATUS)
		|| (s_axi_araddr == OFF_CLK_DIVIDE) || (s_axi_araddr == OFF_CLK_SELECT)
		|| (s_axi_araddr == OFF_DEBUG_CTRL) || rdIndex;

	// read data mux; reserved bits and the write-only control read zero
	always_comb begin
		rdMux = '0;
		unique case (s_axi_araddr)
			OFF_STATUS:     rdMux[POS_STICKY] = sticky_r;
			OFF_CLK_DIVIDE: rdMux[2:0] = ratio_r;
			OFF_CLK_SELECT: rdMux[POS_BUS_PICK:POS_LOW_PICK] = pick_r;
			OFF_DEBUG_CTRL: rdMux[1:0] = dbgCtl_r;
			OFF_IRQ_INDEX:  rdMux[7:0] = link.curIndex;
			default:        rdMux = '0;
		endcase
	end

	// a processor read of the index pops it; a debug read only looks
	assign link.indexRead = rdTake && rdIndex && !arDebug;
	assign link.mask      = interrupt_mask;
	assign link.pick      = pick_r;
	assign link.ratio     = ratio_r;

	// write address and data are taken in either order
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			awReady_r <= 1'b1;
			wReady_r  <= 1'b1;
			wrAddr_r  <= '0;
			wrData_r  <= '0;
			wrStrb_r  <= 4'h0;
		end else begin
			if (s_axi_awvalid && awReady_r) begin
				awReady_r <= 1'b0;
				wrAddr_r  <= s_axi_awaddr;
			end else if (doWrite) begin
				awReady_r <= 1'b1;
			end
			if (s_axi_wvalid && wReady_r) begin
				wReady_r <= 1'b0;
				wrData_r <= s_axi_wdata;
				wrStrb_r <= s_axi_wstrb;
			end else if (doWrite) begin
				wReady_r <= 1'b1;
			end
		end
	end

	// write response one cycle after both halves are held
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			bValid_r <= 1'b0;
			bResp_r  <= RESP_OKAY;
		end else if (doWrite) begin
			bValid_r <= 1'b1;
			bResp_r  <= wrMapped ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			bValid_r <= 1'b0;
		end
	end

	// read answer registered one cycle after the address is taken
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			arReady_r <= 1'b1;
			rValid_r  <= 1'b0;
			rData_r   <= '0;
			rResp_r   <= RESP_OKAY;
		end else if (rdTake) begin
			arReady_r <= 1'b0;
			rValid_r  <= 1'b1;
			rData_r   <= rdMux;
			rResp_r   <= rdMapped ? RESP_OKAY : RESP_SLVERR;
		end else if (rValid_r && s_axi_rready) begin
			arReady_r <= 1'b1;
			rValid_r  <= 1'b0;
		end
	end

	// control registers; only the defined bits are stored
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			ratio_r  <= RST_RATIO;
			pick_r   <= RST_SELECT;
			dbgCtl_r <= RST_DEBUG;
		end else begin
			if (wrDivide) ratio_r <= wrData_r[2:0];
			if (wrSelect) pick_r <= wrData_r[POS_BUS_PICK:POS_LOW_PICK];
			if (wrDebug) dbgCtl_r <= wrData_r[1:0];
		end
	end

	// the flag must never lose a reset, so a set in the same cycle as a keyed
	// clear wins and software sees the flag again on its next read
	// sticky reset flag: a reset in the clearing cycle keeps it set
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			sticky_r     <= 1'b0;
			resetPulse_r <= 1'b0;
		end else begin
			resetPulse_r <= resetAssert;
			if (stickySet) begin
				sticky_r <= 1'b1;
			end else if (stickyClear) begin
				sticky_r <= 1'b0;
			end
		end
	end

	// the halt level comes from the core's domain; the first stage may be
	// metastable and is read only by the second, and a level counts once the
	// second and third stages agree, so a one-cycle glitch is ignored
	// core halt input: three stages, change accepted when stages two and three agree
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			haltS1_r   <= 1'b0;
			haltS2_r   <= 1'b0;
			haltS3_r   <= 1'b0;
			haltSeen_r <= 1'b0;
		end else begin
			haltS1_r <= coreHalted;
			haltS2_r <= haltS1_r;
			haltS3_r <= haltS2_r;
			if (haltS2_r == haltS3_r) haltSeen_r <= haltS3_r;
		end
	end

	// once frozen the boundary is no longer needed: the freeze holds until the
	// halt goes away, even if the peripheral leaves its safe point
	// freeze decision: free run ignores the halt, soft halt waits for a boundary
	logic freezeNxt;
	assign freezeNxt = !dbgCtl_r[POS_FREE] && haltSeen_r
		&& (frozen_r || !dbgCtl_r[POS_SOFT] || safeBoundary);

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			frozen_r <= 1'b0;
			run_r    <= 1'b1;
		end else begin
			frozen_r <= freezeNxt;
			run_r    <= !freezeNxt;
		end
	end

	// the helper results pass one more flop so that every top output comes
	// straight from a register; raw_interrupt_flags shows the flags one cycle later
	// output flops for the helper results
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rawOut_r  <= '0;
			tickOut_r <= 1'b0;
		end else begin
			rawOut_r  <= link.rawFlags;
			tickOut_r <= link.funcTick;
		end
	end

	pcc_clock_gen uClock (
		.sys_clk  (sys_clk),
		.reset_n  (reset_n),
		.busClkEn (busClkEn),
		.midClkEn (midClkEn),
		.lowClkEn (lowClkEn),
		.midTick  (midTick),
		.lowTick  (lowTick),
		.link     (link.clkSide)
	);

	pcc_irq_index uIrq (
		.sys_clk (sys_clk),
		.reset_n (reset_n),
		.events  (irqEvents),
		.link    (link.irqSide)
	);

	// port drive
	assign s_axi_awready       = awReady_r;
	assign s_axi_wready        = wReady_r;
	assign s_axi_bvalid        = bValid_r;
	assign s_axi_bresp         = bResp_r;
	assign s_axi_arready       = arReady_r;
	assign s_axi_rvalid        = rValid_r;
	assign s_axi_rdata         = rData_r;
	assign s_axi_rresp         = rResp_r;
	assign periphResetOut      = resetPulse_r;
	assign raw_interrupt_flags = rawOut_r;
	assign funcClkTick         = tickOut_r;
	assign functionRun         = run_r;
endmodule : peripheral_common_ctrl

// ===== verification/peripheral_common_ctrl_assertions.sv
// port checker of the common control wrapper
// assumes one bus clock and the active-low asynchronous reset
`timescale 1ns/1ns
module peripheral_common_ctrl_assertions
	import pcc_pkg::*;
(
	input wire logic              sys_clk,
	input wire logic              reset_n,
	input wire logic              s_axi_awvalid,
	input wire logic              s_axi_awready,
	input wire logic              s_axi_wvalid,
	input wire logic              s_axi_wready,
	input wire logic              s_axi_bvalid,
	input wire logic              s_axi_arvalid,
	input wire logic              s_axi_arready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic              arDebug,
	input wire logic              s_axi_rvalid,
	input wire logic              s_axi_rready,
	input wire logic [DATA_W-1:0] s_axi_rdata,
	input wire logic              periphResetOut,
	input wire logic [IRQ_N-1:0]  irqEvents,
	input wire logic [IRQ_N-1:0]  raw_interrupt_flags,
	input wire logic              busClkEn,
	input wire logic              midClkEn,
	input wire logic              lowClkEn,
	input wire logic              funcClkTick,
	input wire logic              coreHalted,
	input wire logic              functionRun
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	logic       idxRead_r;
	logic [2:0] offCnt_r;
	logic [3:0] freeCnt_r;

	// marks an index read and counts idle-source and halt-free cycles
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			idxRead_r <= 1'b0;
			offCnt_r  <= 3'h0;
			freeCnt_r <= 4'h0;
		end else begin
			if (s_axi_arvalid && s_axi_arready)
				idxRead_r <= (s_axi_araddr == OFF_IRQ_INDEX);
			offCnt_r  <= (busClkEn | midClkEn | lowClkEn) ? 3'h0 : offCnt_r + {2'h0, offCnt_r != 3'h7};
			freeCnt_r <= coreHalted ? 4'h0 : freeCnt_r + {3'h0, freeCnt_r != 4'hF};
		end
	end

	// bus transfers taken
	sequence wrTake;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rdTake;
		s_axi_arvalid && s_axi_arready;
	endsequence

	AST_WRITE_ANSWER: assert property (wrTake |-> ##[1:2] s_axi_bvalid)
		else $error("write response missing");
	AST_READ_ANSWER: assert property (rdTake |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer missing");
	AST_READ_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	AST_INDEX_CODE: assert property (s_axi_rvalid && idxRead_r |-> s_axi_rdata <= 32'h20)
		else $error("index out of code range");
	AST_DEBUG_KEEPS: assert property ((rdTake and (arDebug && irqEvents == '0))
		|-> ##2 $stable(raw_interrupt_flags))
		else $error("debug read changed flags");
	AST_EVENT_FLAG: assert property (irqEvents != '0 |-> ##2 (raw_interrupt_flags & $past(irqEvents, 2)) == $past(irqEvents, 2))
		else $error("event flag not set");
	AST_NO_SOURCE: assert property (offCnt_r >= 3'h4 |-> !funcClkTick)
		else $error("tick without source");
	AST_RESUME: assert property (freeCnt_r >= 4'h8 |-> functionRun)
		else $error("no resume after halt");
	AST_RESET_PULSE: assert property (periphResetOut |=> !periphResetOut)
		else $error("reset pulse too long");
endmodule : peripheral_common_ctrl_assertions

bind peripheral_common_ctrl peripheral_common_ctrl_assertions checker_i (.*);

// ===== verification/pcc_core_model.sv
// processor side model: core halt and the mid and low source clock ticks
// assumes the bench asks for a halt by a level on sys_clk
`timescale 1ns/1ns
module pcc_core_model #(
	parameter int MID_DIV = 3,
	parameter int LOW_DIV = 5
) (
	input  wire logic sys_clk,
	input  wire logic reset_n,
	input  wire logic haltReq,
	output logic      coreHalted,
	output logic      midTick,
	output logic      lowTick
);
	int midCnt_r;
	int lowCnt_r;

	// halt follows the request one edge later; sources tick once a period
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			coreHalted <= 1'b0;
			midCnt_r   <= 0;
			lowCnt_r   <= 0;
		end else begin
			coreHalted <= haltReq;
			midCnt_r   <= (midCnt_r == MID_DIV - 1) ? 0 : midCnt_r + 1;
			lowCnt_r   <= (lowCnt_r == LOW_DIV - 1) ? 0 : lowCnt_r + 1;
		end
	end

	// one-cycle pulses
	assign midTick = (midCnt_r == MID_DIV - 1);
	assign lowTick = (lowCnt_r == LOW_DIV - 1);
endmodule : pcc_core_model

// ===== verification/test_peripheral_common_ctrl.sv
// bench of the common control wrapper: registers, sticky flag, index, clock, halt
// assumes the design package, the core model and the bound checker
`timescale 1ns/1ns
module test_peripheral_common_ctrl;
	import pcc_pkg::*;
	localparam int MID_DIV = 3;
	localparam int LOW_DIV = 5;
	logic              sys_clk, reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic              s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic              arDebug, s_axi_rvalid, s_axi_rready, periphResetIn, periphResetOut;
	logic              busClkEn, midClkEn, lowClkEn, midTick, lowTick, funcClkTick;
	logic              coreHalted, safeBoundary, functionRun, haltReq;
	logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata, rdVal;
	logic [3:0]        s_axi_wstrb;
	logic [1:0]        s_axi_bresp, s_axi_rresp, resp;
	logic [IRQ_N-1:0]  irqEvents, interrupt_mask, raw_interrupt_flags;
	int                compares, fails, gap;

	peripheral_common_ctrl DUT (.*);
	pcc_core_model #(.MID_DIV(MID_DIV), .LOW_DIV(LOW_DIV)) partner (.sys_clk(sys_clk),
		.reset_n(reset_n), .haltReq(haltReq), .coreHalted(coreHalted), .midTick(midTick),
		.lowTick(lowTick));

	// 50 MHz bus clock
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	// counts and verdict
	task automatic tally_and_finish;
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : tally_and_finish

	// one counted comparison
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// a bounded wait ran out
	task automatic timed_out(input string name);
		fails++;
		$display("[ERR] %s expected handshake seen timeout", name);
		tally_and_finish();
	endtask : timed_out

	// write: address and data offered together, each released when taken
	task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		int n;
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge sys_clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		if (n == 50) timed_out("bvalid");
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge sys_clk);
	endtask : axi_write

	// read, from the processor or the debug side
	task automatic axi_read(input logic [ADDR_W-1:0] a, input logic dbg);
		int n;
		s_axi_araddr  <= a;
		arDebug       <= dbg;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge sys_clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		if (n == 50) timed_out("rvalid");
		rdVal = s_axi_rdata;
		resp  = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge sys_clk);
	endtask : axi_read

	// read and compare
	task automatic rd_chk(input string name, input logic [ADDR_W-1:0] a, input logic [31:0] e,
		input logic dbg);
		axi_read(a, dbg);
		chk(name, e, rdVal);
	endtask : rd_chk

	// cycles between two functional ticks, 100 when none come
	task automatic tick_gap(output int g);
		for (int k = 0; k < 3; k++) begin
			g = 0;
			do begin
				@(posedge sys_clk);
				g++;
			end while (funcClkTick !== 1'b1 && g < 100);
		end
	endtask : tick_gap

	// run level settles to e, or with stay set holds e for 20 cycles
	task automatic run_is(input logic e, input logic stay);
		for (int i = 0; i < 20; i++) begin
			@(posedge sys_clk);
			if ((functionRun === e) != stay) break;
		end
		chk("functionRun", {31'h0, e}, {31'h0, functionRun});
	endtask : run_is

	// main sequence
	initial begin
		static logic [ADDR_W-1:0] regs [5] = '{OFF_STATUS, OFF_CLK_DIVIDE, OFF_CLK_SELECT,
			OFF_DEBUG_CTRL, OFF_IRQ_INDEX};
		static logic [31:0] rstVal [5] = '{32'h0, 32'h0, 32'h0, 32'h3, 32'h0};
		static logic [31:0] fullVal [5] = '{32'h0, 32'h7, 32'hE, 32'h3, 32'h0};
		static logic [31:0] idxSeq [4] = '{32'h1, 32'h2, 32'h19, 32'h0};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{reset_n, arDebug, periphResetIn, busClkEn, midClkEn, lowClkEn} = '0;
		{haltReq, safeBoundary, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{irqEvents, interrupt_mask} = '0;
		s_axi_wstrb = 4'hF;
		compares = 0;
		fails = 0;
		repeat (3) @(posedge sys_clk);
		reset_n <= 1'b1;
		@(posedge sys_clk);
		// reset values, then all-ones writes to expose field widths
		foreach (regs[i]) rd_chk("reset value", regs[i], rstVal[i], 1'b0);
		foreach (regs[i]) begin
			axi_write(regs[i], 32'hFFFF_FFFF);
			rd_chk("field width", regs[i], fullVal[i], 1'b0);
		end
		axi_write(13'h0100, 32'h1);
		chk("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, resp});
		rd_chk("unmapped read", 13'h0100, 32'h0, 1'b0);
		chk("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, resp});
		// sticky flag: set by reset, cleared only with the key
		periphResetIn <= 1'b1;
		@(posedge sys_clk);
		periphResetIn <= 1'b0;
		rd_chk("sticky set", OFF_STATUS, 32'h0001_0000, 1'b0);
		axi_write(OFF_RESET_CTRL, 32'hA500_0002);
		chk("wrong key bresp", {30'h0, RESP_OKAY}, {30'h0, resp});
		rd_chk("wrong key", OFF_STATUS, 32'h0001_0000, 1'b0);
		axi_write(OFF_RESET_CTRL, 32'hB100_0002);
		rd_chk("keyed clear", OFF_STATUS, 32'h0, 1'b0);
		axi_write(OFF_RESET_CTRL, 32'hB100_0001);
		rd_chk("keyed assert", OFF_STATUS, 32'h0001_0000, 1'b0);
		// index: masked events, debug reads, clear on each processor read
		interrupt_mask <= 32'h0100_0003;
		irqEvents      <= 32'h0100_0023;
		@(posedge sys_clk);
		irqEvents <= '0;
		repeat (2) rd_chk("debug index", OFF_IRQ_INDEX, 32'h1, 1'b1);
		foreach (idxSeq[i]) rd_chk("cpu index", OFF_IRQ_INDEX, idxSeq[i], 1'b0);
		chk("raw flags", 32'h0000_0020, raw_interrupt_flags);
		// functional clock: bus source at every ratio, then mid, low, none
		busClkEn <= 1'b1;
		axi_write(OFF_CLK_SELECT, 32'h8);
		for (int r = 0; r < 8; r++) begin
			axi_write(OFF_CLK_DIVIDE, 32'(r));
			tick_gap(gap);
			chk("bus gap", r + 1, gap);
		end
		midClkEn <= 1'b1;
		axi_write(OFF_CLK_SELECT, 32'h4);
		axi_write(OFF_CLK_DIVIDE, 32'h1);
		tick_gap(gap);
		chk("mid gap", 2 * MID_DIV, gap);
		lowClkEn <= 1'b1;
		axi_write(OFF_CLK_SELECT, 32'h2);
		axi_write(OFF_CLK_DIVIDE, 32'h0);
		tick_gap(gap);
		chk("low gap", LOW_DIV, gap);
		{busClkEn, midClkEn, lowClkEn} <= 3'h0;
		axi_write(OFF_CLK_SELECT, 32'h8);
		tick_gap(gap);
		chk("no source", 100, gap);
		// debug halt: free run, immediate freeze, soft freeze at a boundary
		haltReq <= 1'b1;
		run_is(1'b1, 1'b1);
		axi_write(OFF_DEBUG_CTRL, 32'h0);
		run_is(1'b0, 1'b0);
		haltReq <= 1'b0;
		run_is(1'b1, 1'b0);
		axi_write(OFF_DEBUG_CTRL, 32'h2);
		haltReq <= 1'b1;
		run_is(1'b1, 1'b1);
		safeBoundary <= 1'b1;
		run_is(1'b0, 1'b0);
		tally_and_finish();
	end
endmodule : test_peripheral_common_ctrl
